/* hw/card_host_buf.sv */
// Transfer buffer: one write port, registered read port
module card_host_buf
  import card_host_pkg::*;
(
  // Clock and freeze
  input wire logic hclk,
  input wire logic clk_en,
  // Write port
  input wire logic wr_en,
  input wire logic [BUF_AW-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  // Read port
  input wire logic [BUF_AW-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);
  // Storage words
  logic [DATA_W-1:0] mem [2**BUF_AW];

  // Write and registered read
  always_ff @(posedge hclk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule : card_host_buf

/* hw/card_host_ctrl.sv */
// Host-side controller driving a flash card's pins, steered over AHB-Lite
// Notes on behaviour
// - Host grounds strap to pick drive mode
// - No access until ready/busy high again
// - Memory mode space select: high task file
// - I/O mode space select held low
// - Drive mode space select tied high
// - Drive mode memory write tied high
// - I/O and drive modes poll busy status
//
// Added by the designer: the register offsets and register access over AHB-Lite.
module card_host_ctrl
  import card_host_pkg::*;
(
  // Clock, reset, freeze
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Card address, selects and strobes
  output logic [ADDR_W-1:0] card_addr,
  output logic lower_card_select_n,
  output logic upper_card_select_n,
  output logic space_select_n,
  output logic mem_read_strobe_n,
  output logic mem_write_strobe_n,
  output logic io_read_strobe_n,
  output logic io_write_strobe_n,
  output logic card_reset_line,
  // Card data bus, three signals
  input wire logic [DATA_W-1:0] card_data_in,
  output logic [DATA_W-1:0] card_data_out,
  output logic card_data_oe_n,
  // Role pin, grounded or open
  output logic drive_role_select_n,
  output logic drive_role_oe_n,
  // Card outputs seen by the host
  input wire logic ready_busy_line,
  input wire logic service_request_n,
  input wire logic drive_interrupt_line,
  input wire logic word_transfer_flag_n,
  input wire logic card_wait_n,
  input wire logic write_protect,
  input wire logic io_ready_line
);
  // Bus group state
  logic [4:0] ctrl_reg, ctrl_next; // Mode, configured, master, byte
  logic [BUF_AW-1:0] bptr_reg, bptr_next; // Buffer pointer
  logic refused_reg, refused_next; // Last command refused
  logic dp_wr_reg, dp_wr_next; // Write data phase pending
  logic [7:0] dp_addr_reg, dp_addr_next; // Latched offset
  logic [1:0] rd_stage_reg, rd_stage_next; // Read wait stages
  logic hready_reg, hready_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic cmd_go, rst_go, buf_sw_wr; // Bus events to sequencer and buffer
  // Sequencer group state
  seq_t st_reg, st_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [18:0] cmd_reg, cmd_next; // Latched command word
  logic word_seen_reg, word_seen_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic ce1_reg, ce1_next, ce2_reg, ce2_next, reg_reg, reg_next;
  logic oe_reg, oe_next, we_reg, we_next, iord_reg, iord_next, io_write_strobe_n_reg, io_write_strobe_n_next;
  logic rst_pin_reg, rst_pin_next, doe_reg, doe_next, role_oe_reg, role_oe_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic fsm_wr;
  // Synchroniser chain and filtered levels
  logic [SYNC_N-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  logic [DATA_W-1:0] d1_reg, d2_reg, d3_reg;
  // Buffer wiring
  logic [DATA_W-1:0] buf_rd;
  logic [BUF_AW-1:0] buf_wa, buf_ra;
  logic [DATA_W-1:0] buf_wd;
  mode_t mode;
  logic busy;

  assign mode = mode_t'(ctrl_reg[CTRL_MODE_LO +: 2]);
  assign busy = (st_reg != S_IDLE);

  // Register read mux
  function automatic logic [31:0] rd_mux(input logic [7:0] off);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (off == OFF_CTRL) begin
      v[4:0] = ctrl_reg;
    end else if (off == OFF_CMD) begin
      v[18:0] = cmd_reg;
    end else if (off == OFF_STAT) begin
      v[ST_BUSY] = busy;
      v[ST_READY] = filt_reg[0];
      v[ST_SREQ] = ~filt_reg[1];
      v[ST_IRQ] = filt_reg[2];
      v[ST_WORD] = word_seen_reg;
      v[ST_WAIT] = filt_reg[4];
      v[ST_WP] = filt_reg[5];
      v[ST_REFUSED] = refused_reg;
      v[ST_IO_READY_LINE] = filt_reg[6];
    end else if (off == OFF_BPTR) begin
      v[BUF_AW-1:0] = bptr_reg;
    end else if (off == OFF_BDATA) begin
      v[DATA_W-1:0] = buf_rd;
    end
    return v;
  endfunction : rd_mux

  // Bus slave next state and events
  always_comb begin
    logic io_only;
    io_only = 1'b0;
    ctrl_next = ctrl_reg;
    bptr_next = bptr_reg;
    refused_next = refused_reg;
    dp_wr_next = 1'b0;
    dp_addr_next = dp_addr_reg;
    rd_stage_next = rd_stage_reg;
    hready_next = hready_reg;
    hrdata_next = hrdata_reg;
    cmd_go = 1'b0;
    rst_go = 1'b0;
    buf_sw_wr = 1'b0;
    // Data phase of a write
    if (dp_wr_reg) begin
      if (dp_addr_reg == OFF_CTRL) begin
        ctrl_next = hwdata[4:0];
        rst_go = hwdata[CTRL_RESET];
      end else if (dp_addr_reg == OFF_CMD) begin
        // I/O strobes only once the interface is configured
        io_only = (mode == MODE_IDE) || (mode == MODE_IO && hwdata[CMD_TASK]);
        if (busy || (io_only && !ctrl_reg[CTRL_CFG])) begin
          refused_next = 1'b1;
        end else begin
          refused_next = 1'b0;
          cmd_go = 1'b1;
        end
      end else if (dp_addr_reg == OFF_BPTR) begin
        bptr_next = hwdata[BUF_AW-1:0];
      end else if (dp_addr_reg == OFF_BDATA) begin
        buf_sw_wr = !busy;
      end
    end
    // Read wait stages let the buffer settle
    if (rd_stage_reg == 2'd1) begin
      rd_stage_next = 2'd2;
    end else if (rd_stage_reg == 2'd2) begin
      rd_stage_next = 2'd0;
      hrdata_next = rd_mux(dp_addr_reg);
      hready_next = 1'b1;
    end
    // Address phase
    if (hsel && htrans[1] && hready) begin
      dp_addr_next = {haddr[7:2], 2'b00};
      if (hwrite) begin
        dp_wr_next = 1'b1;
      end else begin
        rd_stage_next = 2'd1;
        hready_next = 1'b0;
      end
    end
  end

  // Bus slave registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CTRL_RST_VAL;
      bptr_reg <= '0;
      refused_reg <= 1'b0;
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      rd_stage_reg <= 2'd0;
      hready_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      ctrl_reg <= ctrl_next;
      bptr_reg <= bptr_next;
      refused_reg <= refused_next;
      dp_wr_reg <= dp_wr_next;
      dp_addr_reg <= dp_addr_next;
      rd_stage_reg <= rd_stage_next;
      hready_reg <= hready_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // Synchroniser filter: a change counts once stages two and three agree
  always_comb begin
    filt_next = filt_reg;
    for (int i = 0; i < SYNC_N; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        filt_next[i] = s3_reg[i];
      end
    end
  end

  // Three-stage synchronisers for card outputs and data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
      d1_reg <= '0;
      d2_reg <= '0;
      d3_reg <= '0;
    end else if (clk_en) begin
      s1_reg <= {io_ready_line, write_protect, card_wait_n, word_transfer_flag_n,
                 drive_interrupt_line, service_request_n, ready_busy_line};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
      d1_reg <= card_data_in;
      d2_reg <= d1_reg;
      d3_reg <= d2_reg;
    end
  end

  // Sequencer next state and pin values
  always_comb begin
    logic cmd_io;
    logic wide;
    // I/O strobes in drive mode, or for task file in I/O mode
    cmd_io = (mode == MODE_IDE) || (mode == MODE_IO && cmd_reg[CMD_TASK]);
    // Drive mode stays word wide until byte mode is chosen
    wide = (mode == MODE_IDE) ? !ctrl_reg[CTRL_BYTE] : cmd_reg[CMD_WORD];
    st_next = st_reg;
    cnt_next = cnt_reg;
    cmd_next = cmd_reg;
    word_seen_next = word_seen_reg;
    addr_next = addr_reg;
    dout_next = dout_reg;
    fsm_wr = 1'b0;
    // Idle pin levels per mode
    ce1_next = 1'b1;
    ce2_next = 1'b1;
    iord_next = 1'b1;
    io_write_strobe_n_next = 1'b1;
    we_next = 1'b1;
    doe_next = 1'b1;
    oe_next = (mode != MODE_IDE);
    reg_next = (mode == MODE_IDE);
    rst_pin_next = (mode == MODE_IDE);
    role_oe_next = !ctrl_reg[CTRL_MASTER];
    case (st_reg)
      S_RESET: begin
        rst_pin_next = (mode != MODE_IDE);
        if (cnt_reg >= RESET_CYC - 1'b1) begin
          st_next = S_INIT;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      S_INIT: begin
        // Memory mode waits for ready; other modes poll status
        if (mode != MODE_MEM || filt_reg[0]) begin
          st_next = S_IDLE;
        end
      end
      S_IDLE: begin
        if (cmd_go) begin
          cmd_next = hwdata[18:0];
          st_next = S_SETUP;
          cnt_next = '0;
        end
      end
      S_SETUP: begin
        addr_next = cmd_reg[CMD_ADDR_LO +: ADDR_W];
        if (mode == MODE_IDE) begin
          ce2_next = !cmd_reg[CMD_ALT];
          ce1_next = cmd_reg[CMD_ALT];
        end else begin
          ce1_next = 1'b0;
          ce2_next = !wide;
        end
        if (mode == MODE_MEM) begin
          reg_next = cmd_reg[CMD_TASK];
        end
        dout_next = buf_rd;
        if (cnt_reg >= SETUP_CYC - 1'b1) begin
          st_next = S_STROBE;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      S_STROBE: begin
        ce1_next = lower_card_select_n;
        ce2_next = upper_card_select_n;
        if (mode == MODE_MEM) begin
          reg_next = cmd_reg[CMD_TASK];
        end
        doe_next = !cmd_reg[CMD_WR];
        if (cmd_io) begin
          iord_next = cmd_reg[CMD_WR];
          io_write_strobe_n_next = !cmd_reg[CMD_WR];
        end else begin
          oe_next = cmd_reg[CMD_WR];
          we_next = !cmd_reg[CMD_WR];
        end
        // Card wait stretches the strobe
        if (cnt_reg >= STROBE_CYC - 1'b1 && filt_reg[4]) begin
          st_next = S_HOLD;
          cnt_next = '0;
          word_seen_next = !filt_reg[3];
          fsm_wr = !cmd_reg[CMD_WR];
        end else if (cnt_reg < STROBE_CYC) begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      S_HOLD: begin
        ce1_next = lower_card_select_n;
        ce2_next = upper_card_select_n;
        if (mode == MODE_MEM) begin
          reg_next = cmd_reg[CMD_TASK];
        end
        doe_next = card_data_oe_n;
        if (cnt_reg >= HOLD_CYC - 1'b1) begin
          st_next = S_IDLE;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      default: begin
        st_next = S_IDLE;
      end
    endcase
    // A reset request overrides any access
    if (rst_go) begin
      st_next = S_RESET;
      cnt_next = '0;
    end
  end

  // Sequencer and pin registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= S_RESET;
      cnt_reg <= '0;
      cmd_reg <= '0;
      word_seen_reg <= 1'b0;
      addr_reg <= '0;
      ce1_reg <= 1'b1;
      ce2_reg <= 1'b1;
      reg_reg <= 1'b0;
      oe_reg <= 1'b1;
      we_reg <= 1'b1;
      iord_reg <= 1'b1;
      io_write_strobe_n_reg <= 1'b1;
      rst_pin_reg <= 1'b1;
      doe_reg <= 1'b1;
      role_oe_reg <= 1'b1;
      dout_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      cmd_reg <= cmd_next;
      word_seen_reg <= word_seen_next;
      addr_reg <= addr_next;
      ce1_reg <= ce1_next;
      ce2_reg <= ce2_next;
      reg_reg <= reg_next;
      oe_reg <= oe_next;
      we_reg <= we_next;
      iord_reg <= iord_next;
      io_write_strobe_n_reg <= io_write_strobe_n_next;
      rst_pin_reg <= rst_pin_next;
      doe_reg <= doe_next;
      role_oe_reg <= role_oe_next;
      dout_reg <= dout_next;
    end
  end

  // Buffer ports: sequencer owns them while busy
  assign buf_wa = fsm_wr ? cmd_reg[CMD_IDX_LO +: BUF_AW] : bptr_reg;
  assign buf_wd = fsm_wr ? d3_reg : hwdata[DATA_W-1:0];
  assign buf_ra = busy ? cmd_reg[CMD_IDX_LO +: BUF_AW] : bptr_reg;

  card_host_buf u_buf (
    .hclk(hclk),
    .clk_en(clk_en),
    .wr_en(fsm_wr || buf_sw_wr),
    .wr_addr(buf_wa),
    .wr_data(buf_wd),
    .rd_addr(buf_ra),
    .rd_data(buf_rd)
  );

  // Outputs straight from flip-flops, except hresp and drive_role_select_n, which are tied low
  assign hreadyout = hready_reg;
  assign hrdata = hrdata_reg;
  assign hresp = 1'b0 & hready_reg;
  assign card_addr = addr_reg;
  assign lower_card_select_n = ce1_reg;
  assign upper_card_select_n = ce2_reg;
  assign space_select_n = reg_reg;
  assign mem_read_strobe_n = oe_reg;
  assign mem_write_strobe_n = we_reg;
  assign io_read_strobe_n = iord_reg;
  assign io_write_strobe_n = io_write_strobe_n_reg;
  assign card_reset_line = rst_pin_reg;
  assign card_data_out = dout_reg;
  assign card_data_oe_n = doe_reg;
  assign drive_role_select_n = 1'b0 & role_oe_reg;
  assign drive_role_oe_n = role_oe_reg;

  // Checks on the pins this host drives and on its sequencer state
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !clk_en);

  a_ide_strap_low: assert property (
    (mode == MODE_IDE && $past(mode) == MODE_IDE) |-> !mem_read_strobe_n)
    else $error("strap not grounded in drive mode");
  a_ide_space_high: assert property (
    (mode == MODE_IDE && $past(mode) == MODE_IDE) |-> space_select_n)
    else $error("space select not high in drive mode");
  a_ide_write_high: assert property (
    (mode == MODE_IDE && $past(mode) == MODE_IDE) |-> mem_write_strobe_n)
    else $error("memory write strobe active in drive mode");
  a_io_space_low: assert property (
    (mode == MODE_IO && $past(mode) == MODE_IO) |-> !space_select_n)
    else $error("space select high in I/O mode");
  a_io_write_cfg: assert property (
    $fell(io_write_strobe_n) |-> ctrl_reg[CTRL_CFG])
    else $error("I/O write before interface configured");
  a_init_hold: assert property (
    (st_reg == S_INIT && mode == MODE_MEM && !filt_reg[0] && !rst_go) |=> st_reg == S_INIT)
    else $error("access left init while card busy");
  a_reset_level: assert property (
    ($past(st_reg) == S_RESET && $past(mode) == MODE_IDE) |-> !card_reset_line)
    else $error("drive mode reset not low");
  a_strobe_width: assert property (
    $fell(io_write_strobe_n) |=> !io_write_strobe_n [*8])
    else $error("I/O write strobe too short");
  a_role_ground: assert property (
    ctrl_reg[CTRL_MASTER] |=> !drive_role_oe_n)
    else $error("role pin not grounded for master");
endmodule : card_host_ctrl

/* hw/card_host_pkg.sv */
// Constants, field layouts and types shared by the card host controller
package card_host_pkg;
  // Bus register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_BPTR = 8'h0C;
  localparam logic [7:0] OFF_BDATA = 8'h10;
  // Control register fields
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_CFG = 2;
  localparam int CTRL_MASTER = 3;
  localparam int CTRL_BYTE = 4;
  localparam int CTRL_RESET = 5;
  localparam logic [4:0] CTRL_RST_VAL = 5'h00;
  // Command register fields
  localparam int CMD_WR = 0;
  localparam int CMD_TASK = 1;
  localparam int CMD_WORD = 2;
  localparam int CMD_ALT = 3;
  localparam int CMD_IDX_LO = 4;
  localparam int CMD_ADDR_LO = 8;
  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_READY = 1;
  localparam int ST_SREQ = 2;
  localparam int ST_IRQ = 3;
  localparam int ST_WORD = 4;
  localparam int ST_WAIT = 5;
  localparam int ST_WP = 6;
  localparam int ST_REFUSED = 7;
  localparam int ST_IO_READY_LINE = 8;
  // Widths and depths
  localparam int ADDR_W = 11;
  localparam int DATA_W = 16;
  localparam int BUF_AW = 4;
  localparam int CNT_W = 12;
  localparam int SYNC_N = 7;
  // Timing in nanoseconds, then in clock cycles
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_SETUP_NS = 30;
  localparam int T_STROBE_NS = 150;
  localparam int T_HOLD_NS = 20;
  localparam int T_RESET_NS = 10000;
  // Least times round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc
  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'(ns_to_cyc(T_SETUP_NS));
  localparam logic [CNT_W-1:0] STROBE_CYC = CNT_W'(ns_to_cyc(T_STROBE_NS));
  localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'(ns_to_cyc(T_HOLD_NS));
  localparam logic [CNT_W-1:0] RESET_CYC = CNT_W'(ns_to_cyc(T_RESET_NS));
  // Card operating modes
  typedef enum logic [1:0] {
    MODE_MEM = 2'b00,
    MODE_IO = 2'b01,
    MODE_IDE = 2'b10
  } mode_t;
  // Sequencer states
  typedef enum logic [2:0] {
    S_RESET = 3'b000,
    S_INIT = 3'b001,
    S_IDLE = 3'b010,
    S_SETUP = 3'b011,
    S_STROBE = 3'b100,
    S_HOLD = 3'b101
  } seq_t;
endpackage : card_host_pkg

/* test/card_host_ctrl_tb_top.sv */
// Self-checking bench for the card host controller
module card_host_ctrl_tb_top
  import card_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, sreq_n = 1'b1, irq = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0;
  logic hreadyout, hresp, lower_card_select_n, upper_card_select_n, space_select_n;
  logic mem_read_strobe_n, mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n;
  logic card_reset_line, card_data_oe_n, drive_role_select_n, drive_role_oe_n, drive = 1'b0;
  logic ready_busy_line, service_request_n, drive_interrupt_line, word_transfer_flag_n;
  logic card_wait_n, write_protect, io_ready_line;
  logic [ADDR_W-1:0] card_addr;
  logic [DATA_W-1:0] card_data_in, card_data_out;
  logic [6:0] seen; // Pins seen while a strobe was low
  int mismatches = 0, check_count = 0;
  // Clock
  always #2.5 hclk = ~hclk;
  card_host_ctrl card_host_ctrl_inst (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .card_addr, .lower_card_select_n, .upper_card_select_n, .space_select_n, .mem_read_strobe_n,
    .mem_write_strobe_n, .io_read_strobe_n, .io_write_strobe_n, .card_reset_line, .card_data_in,
    .card_data_out, .card_data_oe_n, .drive_role_select_n, .drive_role_oe_n, .ready_busy_line,
    .service_request_n, .drive_interrupt_line, .word_transfer_flag_n, .card_wait_n,
    .write_protect, .io_ready_line);
  card_model card_model_inst (.hclk, .sreq_n_in(sreq_n), .irq_in(irq), .card_addr,
    .lower_card_select_n, .upper_card_select_n, .space_select_n, .mem_read_strobe_n,
    .mem_write_strobe_n, .io_read_strobe_n, .io_write_strobe_n, .card_reset_line, .card_data_out,
    .card_data_in, .ready_busy_line, .service_request_n, .drive_interrupt_line,
    .word_transfer_flag_n, .card_wait_n, .write_protect, .io_ready_line);
  // Pin monitor: {upper, lower, space, mrd, mwr, iord, io_write_strobe_n}
  always @(posedge hclk)
    if (!(lower_card_select_n && upper_card_select_n) && (!mem_write_strobe_n ||
        !io_read_strobe_n || !io_write_strobe_n || (!mem_read_strobe_n && !drive)))
      seen <= {upper_card_select_n, lower_card_select_n, space_select_n, mem_read_strobe_n,
        mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n};
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // Bounded wait for hreadyout high at an edge
  task automatic hold_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      complete_run();
    end
  endtask : hold_ready
  // One AHB-Lite single word transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    hold_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    hold_ready();
    rd = hrdata;
  endtask : bus
  // Poll status until the card access ends
  task automatic idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, OFF_STAT, '0);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 1000);
    if (rd[ST_BUSY] !== 1'b0) begin
      mismatches++;
      complete_run();
    end
  endtask : idle
  function automatic logic [31:0] mk(logic w, logic t, logic wd, logic al, logic [3:0] ix,
    logic [10:0] ad);
    return {13'h0000, ad, ix, al, wd, t, w};
  endfunction : mk
  // Issue a card command and compare the pins seen at the strobe
  task automatic cmd(input logic [31:0] c, input logic [6:0] p);
    seen <= 7'h7F;
    bus(1'b1, OFF_CMD, c);
    idle();
    check(seen, p);
  endtask : cmd
  task automatic wrbuf(input logic [3:0] ix, input logic [15:0] d);
    bus(1'b1, OFF_BPTR, {28'h000_0000, ix});
    bus(1'b1, OFF_BDATA, {16'h0000, d});
  endtask : wrbuf
  task automatic rdbuf(input logic [3:0] ix);
    bus(1'b1, OFF_BPTR, {28'h000_0000, ix});
    bus(1'b0, OFF_BDATA, '0);
  endtask : rdbuf
  // Reset values, static card pins, unmapped place
  task automatic s_reset();
    check(card_reset_line, 1'b1);
    idle();
    check(rd[ST_READY], 1'b1);
    check(rd[ST_WP], 1'b0);
    check(rd[ST_WAIT], 1'b1);
    bus(1'b0, OFF_CTRL, '0);
    check(rd[4:0], CTRL_RST_VAL);
    bus(1'b0, 8'h1C, '0);
    check(rd, '0);
  endtask : s_reset
  // Memory mode: both spaces, refusal while busy
  task automatic s_mem();
    wrbuf(4'h1, 16'h1234);
    cmd(mk(1, 1, 1, 0, 4'h1, 11'h005), 7'b0011011);
    wrbuf(4'h1, 16'h0056);
    cmd(mk(1, 0, 0, 0, 4'h1, 11'h005), 7'b1001011);
    cmd(mk(0, 1, 1, 0, 4'h2, 11'h005), 7'b0010111);
    rdbuf(4'h2);
    check(rd[15:0], 16'h1234);
    cmd(mk(0, 0, 1, 0, 4'h3, 11'h005), 7'b0000111);
    rdbuf(4'h3);
    check(rd[7:0], 8'h56);
    bus(1'b1, OFF_CMD, mk(0, 1, 1, 0, 4'h4, 11'h005));
    bus(1'b1, OFF_CMD, mk(0, 1, 1, 0, 4'h4, 11'h006));
    idle();
    check(rd[ST_REFUSED], 1'b1);
  endtask : s_mem
  // I/O mode: set up, refusal, word flag, service request
  task automatic s_io();
    bus(1'b1, OFF_CTRL, 32'h0000_0001);
    wrbuf(4'h1, 16'h0001);
    cmd(mk(1, 0, 1, 0, 4'h1, 11'h200), 7'b0001011);
    bus(1'b1, OFF_CMD, mk(1, 1, 1, 0, 4'h1, 11'h007));
    idle();
    check(rd[ST_REFUSED], 1'b1);
    bus(1'b1, OFF_CTRL, 32'h0000_0005);
    wrbuf(4'h1, 16'hBEEF);
    cmd(mk(1, 1, 1, 0, 4'h1, 11'h007), 7'b0001110);
    check(rd[ST_WORD], 1'b1);
    cmd(mk(0, 1, 1, 0, 4'h4, 11'h007), 7'b0001101);
    rdbuf(4'h4);
    check(rd[15:0], 16'hBEEF);
    cmd(mk(0, 0, 1, 0, 4'h5, 11'h200), 7'b0000111);
    rdbuf(4'h5);
    check(rd[7:0], 8'h01);
    sreq_n <= 1'b0;
    repeat (8) @(posedge hclk);
    bus(1'b0, OFF_STAT, '0);
    check(rd[ST_SREQ], 1'b1);
    sreq_n <= 1'b1;
  endtask : s_io
  // Drive mode: strap, ties, role, low reset, selects, interrupt
  task automatic s_drive();
    drive = 1'b1;
    bus(1'b1, OFF_CTRL, 32'h0000_000E);
    repeat (2) @(posedge hclk);
    check(mem_read_strobe_n, 1'b0);
    check(space_select_n, 1'b1);
    check(mem_write_strobe_n, 1'b1);
    check(drive_role_oe_n, 1'b0);
    bus(1'b1, OFF_CTRL, 32'h0000_002E);
    repeat (2) @(posedge hclk);
    check(card_reset_line, 1'b0);
    idle();
    cmd(mk(0, 1, 0, 0, 4'h7, 11'h005), 7'b1010101);
    rdbuf(4'h7);
    check(rd[15:0], 16'h0000);
    wrbuf(4'h1, 16'hC0DE);
    cmd(mk(1, 1, 0, 0, 4'h1, 11'h003), 7'b1010110);
    check(rd[ST_WORD], 1'b1);
    cmd(mk(0, 1, 0, 1, 4'h6, 11'h006), 7'b0110101);
    cmd(mk(0, 1, 0, 0, 4'h2, 11'h003), 7'b1010101);
    rdbuf(4'h2);
    check(rd[15:0], 16'hC0DE);
    irq <= 1'b1;
    repeat (8) @(posedge hclk);
    bus(1'b0, OFF_STAT, '0);
    check(rd[ST_IRQ], 1'b1);
    bus(1'b1, OFF_CTRL, 32'h0000_0006);
    repeat (2) @(posedge hclk);
    check(drive_role_oe_n, 1'b1);
    check({hresp, drive_role_select_n, card_data_oe_n}, 3'b001);
  endtask : s_drive
  // Main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_reset();
    s_mem();
    s_io();
    s_drive();
    complete_run();
  end
endmodule : card_host_ctrl_tb_top

/* test/card_model.sv */
// Behavioural flash card answering the host controller's pins
module card_model
  import card_host_pkg::*;
#(
  parameter int INIT_CYC = 50,
  parameter logic [10:0] CFG_ADDR = 11'h200
) (
  // Clock and scenario controls
  input wire logic hclk,
  input wire logic sreq_n_in,
  input wire logic irq_in,
  // Pins from the host
  input wire logic [ADDR_W-1:0] card_addr,
  input wire logic lower_card_select_n,
  input wire logic upper_card_select_n,
  input wire logic space_select_n,
  input wire logic mem_read_strobe_n,
  input wire logic mem_write_strobe_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic card_reset_line,
  input wire logic [DATA_W-1:0] card_data_out,
  // Pins to the host
  output logic [DATA_W-1:0] card_data_in,
  output logic ready_busy_line,
  output logic service_request_n,
  output logic drive_interrupt_line,
  output logic word_transfer_flag_n,
  output logic card_wait_n,
  output logic write_protect,
  output logic io_ready_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] tf [16] = '{default: '0}; // Task file words
  logic [7:0] at [16] = '{default: '0}; // Attribute bytes
  logic ide = 1'b0; // Drive mode strap seen
  logic io_cfg = 1'b0; // I/O interface set up
  int busy_cnt = INIT_CYC; // Initialization countdown
  logic [DATA_W-1:0] last = '0; // Last bus value, inverted when released
  logic mwr_q = 1'b1;
  logic io_write_strobe_n_q = 1'b1;
  logic sel, rst_on, rd_ok;
  logic [3:0] a;
  assign a = card_addr[3:0];
  assign sel = !(lower_card_select_n && upper_card_select_n);
  assign rst_on = ide ? !card_reset_line : card_reset_line;
  // Strap, reset, writes
  always @(posedge hclk) begin
    mwr_q <= mem_write_strobe_n;
    io_write_strobe_n_q <= io_write_strobe_n;
    last <= card_data_in;
    if (!sel) ide <= !mem_read_strobe_n;
    if (rst_on) begin
      busy_cnt <= INIT_CYC;
      io_cfg <= 1'b0;
      if (ide) tf <= '{default: '0};
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
    end else if (sel && !mwr_q && mem_write_strobe_n && !ide) begin
      if (!space_select_n) begin
        at[a] <= card_data_out[7:0];
        if (card_addr == CFG_ADDR) io_cfg <= card_data_out[0];
      end else if (!io_cfg) begin
        tf[a] <= card_data_out;
      end
    end else if (sel && !io_write_strobe_n_q && io_write_strobe_n && (io_cfg || ide)) begin
      tf[a] <= card_data_out;
    end
  end
  // Read gating per mode
  assign rd_ok = sel && (ide ? !io_read_strobe_n : ((!mem_read_strobe_n &&
    !(io_cfg && space_select_n)) || (!io_read_strobe_n && io_cfg)));
  always_comb begin
    if (!rd_ok) card_data_in = ~last;
    else if (!ide && !mem_read_strobe_n && !space_select_n) card_data_in = {~last[15:8], at[a]};
    else card_data_in = tf[a];
  end
  // Status pins
  assign ready_busy_line = (busy_cnt == 0);
  assign service_request_n = sreq_n_in;
  assign drive_interrupt_line = irq_in;
  assign word_transfer_flag_n = ide ? 1'b0 : !(io_cfg && sel && !lower_card_select_n &&
    !upper_card_select_n && !(io_read_strobe_n && io_write_strobe_n));
  assign card_wait_n = 1'b1;
  assign write_protect = 1'b0;
  assign io_ready_line = 1'bz;
endmodule : card_model
